// ---- shared/aos_pkg.sv ----
// constants, field layouts and state codes of the analog output sequencer
package aos_pkg;
    // ----------------------------------------------------------------
    // clocking and rate generator
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned MAX_SPS = 300000;
    // fastest update period in cycles, least time so rounded up
    localparam int unsigned DIV_MIN = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
    // 20 bits reach the 400 sps divisor of one generator
    localparam int DIV_W = 20;
    localparam logic [DIV_W-1:0] RATE_RST = DIV_W'(DIV_MIN);

    // ----------------------------------------------------------------
    // sample fifo and word layout
    // ----------------------------------------------------------------
    localparam int AW = 15;
    localparam int LVL_W = 16;
    localparam logic [LVL_W-1:0] FIFO_DEPTH = 16'h8000;
    localparam int WORD_W = 21;
    localparam int DATA_LSB = 0;
    localparam int DATA_W = 16;
    localparam int CHAN_LSB = 16;
    localparam int GEND_BIT = 19;
    localparam int BEND_BIT = 20;
    localparam logic [AW-1:0] THRESH_RST = 15'h0000;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_THRESH = 8'h08;
    localparam logic [7:0] ADR_RATE_A = 8'h0c;
    localparam logic [7:0] ADR_RATE_B = 8'h10;
    localparam logic [7:0] ADR_FIFO = 8'h14;
    localparam logic [7:0] ADR_DIGOUT = 8'h18;
    localparam logic [7:0] ADR_DMA_ADR = 8'h1c;
    localparam logic [7:0] ADR_DMA_CNT = 8'h20;

    // ----------------------------------------------------------------
    // control and status field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CSRC_LSB = 2;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_CASC_BIT = 5;
    localparam int CTRL_CLR_BIT = 6;
    localparam int CTRL_SW_BIT = 7;
    localparam int CTRL_IRQT_BIT = 8;
    localparam int CTRL_IRQD_BIT = 9;
    localparam int STAT_THR_BIT = 16;
    localparam int STAT_RUN_BIT = 17;
    localparam int STAT_BUSY_BIT = 18;
    localparam int STAT_DONE_BIT = 19;

    // ----------------------------------------------------------------
    // modes, clock sources and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        AOS_M_SIM_CONT = 2'h0,
        AOS_M_SIM_BURST = 2'h1,
        AOS_M_SEQ_CONT = 2'h2,
        AOS_M_SEQ_BURST = 2'h3
    } aos_mode_t;
    localparam logic [1:0] CSRC_RATE = 2'h0;
    localparam logic [1:0] CSRC_SOFT = 2'h1;
    localparam logic [1:0] CSRC_EXT = 2'h2;
    typedef enum logic [2:0] {
        AOS_ST_IDLE = 3'h1,
        AOS_ST_RUN = 3'h2,
        AOS_ST_HOLD = 3'h4
    } aos_state_t;
endpackage

// ---- hw/aos_rate_gen.sv ----
// programmable divider producing one-cycle rate ticks
`timescale 1ns/10ps
module aos_rate_gen #(
    parameter int W = 20
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // divisor and count enable
    input wire logic [W-1:0] div_i,
    input wire logic step_i,
    // tick out
    output logic tick_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } aos_rg_t;

    aos_rg_t s, nxt;
    logic [W-1:0] last;

    // a divisor of zero behaves as one, so the generator never stalls
    always_comb begin
        last = (div_i <= W'(1)) ? '0 : div_i - W'(1);
        nxt = s;
        nxt.tick = 1'b0;
        if (step_i) begin
            if (s.cnt >= last) begin
                nxt.cnt = '0;
                nxt.tick = 1'b1;
            end else begin
                nxt.cnt = s.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign tick_o = s.tick;

    AST_TICK_GAP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tick_o && div_i > W'(1) && $stable(div_i) |=> !tick_o)
        else $error("rate tick repeated before divisor elapsed");
endmodule

// ---- hw/aos_sequencer.sv ----
// output sample fifo, converter sequencer, dma fetch and wishbone registers
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/10ps
// Summary of operation
// - simultaneous continuous: hold group, load on clock
// - update clock from rate, software or trigger
// - burst starts only on software or hardware sync
// - burst loads each gathered group per rate tick
// - burst-end entry ends burst, await next sync
// - sequential modes write each value straight out
// - sequential modes ignore the group-end mark
// - three-bit selector picks the target channel
// - group-end mark closes a channel group
// - burst-end mark flags last burst value
// - 32K-sample fifo with programmable threshold flag
// - dma master fetches samples into the fifo
// - all interrupt causes share one line
// - host accesses are 32-bit data transfers
// - four software-driven digital output lines
// - rate generators, cascadable for slow rates
// - sync-paced updates accept any rate
// - samples and converter codes are 16 bits
module aos_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // wishbone dma read master
    output logic dma_cyc_o,
    output logic dma_stb_o,
    output logic [31:0] dma_adr_o,
    input wire logic [31:0] dma_dat_i,
    input wire logic dma_ack_i,
    // external trigger
    input wire logic ext_trig_i,
    // converters, digital lines, interrupt
    output logic [8*aos_pkg::DATA_W-1:0] dac_data_o,
    output logic [7:0] dac_upd_o,
    output logic [3:0] dig_o,
    output logic irq_o
);
    import aos_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        logic [1:0] mode;
        logic [1:0] csrc;
        logic en;
        logic casc;
        logic irq_thr_en;
        logic irq_dma_en;
        logic [AW-1:0] thresh;
        logic [DIV_W-1:0] div_a;
        logic [DIV_W-1:0] div_b;
        logic [3:0] dig;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [LVL_W-1:0] level;
        logic thr_flag;
        aos_state_t state;
        logic [7:0][DATA_W-1:0] hold;
        logic [7:0][DATA_W-1:0] dac;
        logic [7:0] dac_upd;
        logic bend_seen;
        logic trig_prev;
        logic sw_pulse;
        logic dma_cyc;
        logic [31:0] dma_adr;
        logic [15:0] dma_cnt;
        logic dma_busy;
        logic dma_done;
        logic irq;
    } aos_state_reg_t;

    aos_state_reg_t s, nxt;

    // sample store; no reset, contents only valid below the level
    logic [WORD_W-1:0] mem [0:(1<<AW)-1];

    logic push;
    logic pop;
    logic [WORD_W-1:0] push_word;
    logic [WORD_W-1:0] rd_word;
    logic [DATA_W-1:0] w_data;
    logic [2:0] w_chan;
    logic w_gend;
    logic w_bend;
    logic tick_a;
    logic tick_b;
    logic rate_tick;
    logic trig_rise;
    logic sync_evt;
    logic upd_clk;
    logic is_seq;
    logic is_burst;
    logic fifo_empty;
    logic fifo_full;
    logic wb_req;
    logic [7:0] reg_adr;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // rate generators; the second counts ticks of the first when cascaded
    // ----------------------------------------------------------------
    aos_rate_gen #(.W(DIV_W)) u_rate_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_i(s.div_a),
        .step_i(1'b1),
        .tick_o(tick_a)
    );

    aos_rate_gen #(.W(DIV_W)) u_rate_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_i(s.div_b),
        .step_i(s.casc ? tick_a : 1'b1),
        .tick_o(tick_b)
    );

    // fifo word fields
    assign rd_word = mem[s.rd_ptr];
    assign w_data = rd_word[DATA_LSB +: DATA_W];
    assign w_chan = rd_word[CHAN_LSB +: 3];
    assign w_gend = rd_word[GEND_BIT];
    assign w_bend = rd_word[BEND_BIT];

    // clock and sync selection; trigger is synchronous, edge taken here
    always_comb begin
        rate_tick = s.casc ? tick_b : tick_a;
        trig_rise = ext_trig_i & ~s.trig_prev;
        sync_evt = s.sw_pulse | trig_rise;
        is_seq = s.mode[1];
        is_burst = s.mode[0];
        // bursts are always paced by the rate generator
        if (is_burst) begin
            upd_clk = rate_tick;
        end else if (s.csrc == CSRC_SOFT) begin
            upd_clk = s.sw_pulse;
        end else if (s.csrc == CSRC_EXT) begin
            upd_clk = trig_rise;
        end else begin
            upd_clk = rate_tick;
        end
        fifo_empty = (s.level == '0);
        fifo_full = (s.level == FIFO_DEPTH);
        wb_req = wb_cyc_i & wb_stb_i & ~s.wb_ack;
        reg_adr = {wb_adr_i[7:2], 2'b00};
    end

    // register read mux; unmapped words read as zero
    always_comb begin
        rd_val = 32'h0;
        unique case (reg_adr)
            ADR_CTRL: begin
                rd_val[CTRL_MODE_LSB +: 2] = s.mode;
                rd_val[CTRL_CSRC_LSB +: 2] = s.csrc;
                rd_val[CTRL_EN_BIT] = s.en;
                rd_val[CTRL_CASC_BIT] = s.casc;
                rd_val[CTRL_IRQT_BIT] = s.irq_thr_en;
                rd_val[CTRL_IRQD_BIT] = s.irq_dma_en;
            end
            ADR_STATUS: begin
                rd_val[LVL_W-1:0] = s.level;
                rd_val[STAT_THR_BIT] = s.thr_flag;
                rd_val[STAT_RUN_BIT] = (s.state != AOS_ST_IDLE);
                rd_val[STAT_BUSY_BIT] = s.dma_busy;
                rd_val[STAT_DONE_BIT] = s.dma_done;
            end
            ADR_THRESH: rd_val[AW-1:0] = s.thresh;
            ADR_RATE_A: rd_val[DIV_W-1:0] = s.div_a;
            ADR_RATE_B: rd_val[DIV_W-1:0] = s.div_b;
            ADR_DIGOUT: rd_val[3:0] = s.dig;
            ADR_DMA_ADR: rd_val = s.dma_adr;
            ADR_DMA_CNT: rd_val[15:0] = s.dma_cnt;
            default: rd_val = 32'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state: bus slave, dma, fifo and sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt = s;
        push = 1'b0;
        pop = 1'b0;
        push_word = '0;
        nxt.sw_pulse = 1'b0;
        nxt.dac_upd = 8'h00;
        nxt.trig_prev = ext_trig_i;
        nxt.wb_ack = wb_req; // one wait state, then ack for one cycle
        if (wb_req && !wb_we_i) begin
            nxt.wb_dat = rd_val;
        end
        // writes take only whole words
        if (wb_req && wb_we_i && wb_sel_i == 4'hf) begin
            unique case (reg_adr)
                ADR_CTRL: begin
                    nxt.mode = wb_dat_i[CTRL_MODE_LSB +: 2];
                    nxt.csrc = wb_dat_i[CTRL_CSRC_LSB +: 2];
                    nxt.en = wb_dat_i[CTRL_EN_BIT];
                    nxt.casc = wb_dat_i[CTRL_CASC_BIT];
                    nxt.irq_thr_en = wb_dat_i[CTRL_IRQT_BIT];
                    nxt.irq_dma_en = wb_dat_i[CTRL_IRQD_BIT];
                    nxt.sw_pulse = wb_dat_i[CTRL_SW_BIT];
                end
                ADR_STATUS: begin
                    if (wb_dat_i[STAT_DONE_BIT]) begin
                        nxt.dma_done = 1'b0;
                    end
                end
                ADR_THRESH: nxt.thresh = wb_dat_i[AW-1:0];
                ADR_RATE_A: nxt.div_a = wb_dat_i[DIV_W-1:0];
                ADR_RATE_B: nxt.div_b = wb_dat_i[DIV_W-1:0];
                ADR_DIGOUT: nxt.dig = wb_dat_i[3:0];
                ADR_DMA_ADR: nxt.dma_adr = {wb_dat_i[31:2], 2'b00};
                ADR_DMA_CNT: begin
                    nxt.dma_cnt = wb_dat_i[15:0];
                    nxt.dma_busy = (wb_dat_i[15:0] != 16'h0);
                end
                // software push is refused while dma owns the write port
                ADR_FIFO: begin
                    if (!fifo_full && !s.dma_cyc) begin
                        push = 1'b1;
                        push_word = wb_dat_i[WORD_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // dma: one word per classic cycle, launched only with room left
        if (s.dma_cyc) begin
            if (dma_ack_i) begin
                push = 1'b1;
                push_word = dma_dat_i[WORD_W-1:0];
                nxt.dma_cyc = 1'b0;
                nxt.dma_adr = s.dma_adr + 32'h4;
                nxt.dma_cnt = s.dma_cnt - 16'h1;
                if (s.dma_cnt == 16'h1) begin
                    nxt.dma_busy = 1'b0;
                    nxt.dma_done = 1'b1; // set wins over clear
                end
            end
        end else if (s.dma_busy && !fifo_full) begin
            nxt.dma_cyc = 1'b1;
        end

        // sequencer
        unique case (s.state)
            AOS_ST_IDLE: begin
                if (s.en && (!is_burst || sync_evt)) begin
                    nxt.state = AOS_ST_RUN;
                    nxt.bend_seen = 1'b0;
                end
            end
            AOS_ST_RUN: begin
                if (!is_seq) begin
                    // gather the group as fast as the fifo delivers it
                    if (!fifo_empty) begin
                        pop = 1'b1;
                        nxt.hold[w_chan] = w_data;
                        nxt.bend_seen = s.bend_seen | w_bend;
                        if (w_gend || (is_burst && w_bend)) begin
                            nxt.state = AOS_ST_HOLD;
                        end
                    end
                end else if (upd_clk && !fifo_empty) begin
                    pop = 1'b1;
                    nxt.dac[w_chan] = w_data;
                    nxt.dac_upd[w_chan] = 1'b1;
                    if (is_burst && w_bend) begin
                        nxt.state = AOS_ST_IDLE;
                    end
                end
            end
            AOS_ST_HOLD: begin
                if (upd_clk) begin
                    nxt.dac = s.hold;
                    nxt.dac_upd = 8'hff;
                    nxt.bend_seen = 1'b0;
                    nxt.state = (is_burst && s.bend_seen) ? AOS_ST_IDLE : AOS_ST_RUN;
                end
            end
        endcase
        if (!s.en) begin
            nxt.state = AOS_ST_IDLE;
        end

        // fifo pointers and level; clear discards everything
        if (push) begin
            nxt.wr_ptr = s.wr_ptr + AW'(1);
        end
        if (pop) begin
            nxt.rd_ptr = s.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            nxt.level = s.level + 16'h1;
        end else if (pop && !push) begin
            nxt.level = s.level - 16'h1;
        end
        if (wb_req && wb_we_i && wb_sel_i == 4'hf && reg_adr == ADR_CTRL &&
            wb_dat_i[CTRL_CLR_BIT]) begin
            nxt.wr_ptr = '0;
            nxt.rd_ptr = '0;
            nxt.level = '0;
        end

        // threshold and the single shared interrupt
        nxt.thr_flag = (s.level > {1'b0, s.thresh});
        nxt.irq = (s.irq_thr_en & s.thr_flag) | (s.irq_dma_en & s.dma_done);
    end

    // sample store write port; the word shares the pointer update edge
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[s.wr_ptr] <= push_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.state <= AOS_ST_IDLE;
            s.div_a <= RATE_RST;
            s.div_b <= RATE_RST;
            s.thresh <= THRESH_RST;
        end else begin
            s <= nxt;
        end
    end

    // outputs straight from the state register
    assign wb_ack_o = s.wb_ack;
    assign wb_dat_o = s.wb_dat;
    assign dma_cyc_o = s.dma_cyc;
    assign dma_stb_o = s.dma_cyc;
    assign dma_adr_o = s.dma_adr;
    assign dac_data_o = s.dac;
    assign dac_upd_o = s.dac_upd;
    assign dig_o = s.dig;
    assign irq_o = s.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking aos_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_WB_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus request not acknowledged for exactly one cycle");

    AST_GROUP_LOAD: assert property (
        s.state == AOS_ST_HOLD && upd_clk && s.en |=> dac_upd_o == 8'hff)
        else $error("held group not loaded on update clock");

    AST_BURST_WAIT: assert property (
        s.state == AOS_ST_IDLE && is_burst && !sync_evt |=> s.state == AOS_ST_IDLE)
        else $error("burst started without sync");

    AST_BURST_END: assert property (
        pop && is_seq && is_burst && w_bend && s.en |=> s.state == AOS_ST_IDLE)
        else $error("burst not ended by burst-end entry");

    AST_SEQ_DIRECT: assert property (
        pop && is_seq |=> dac_upd_o == (8'h01 << $past(w_chan)) &&
        dac_data_o[$past(w_chan)*DATA_W +: DATA_W] == $past(w_data))
        else $error("sequential value not written to its channel");

    AST_SEQ_NO_GROUP: assert property (
        is_seq && s.state == AOS_ST_RUN |=> s.state != AOS_ST_HOLD)
        else $error("group-end honoured in sequential mode");

    AST_THRESH: assert property (
        s.level > {1'b0, s.thresh} ##1 s.level > {1'b0, s.thresh} |-> s.thr_flag)
        else $error("threshold flag low above threshold");

    AST_IRQ: assert property (
        s.irq_dma_en && s.dma_done ##1 s.irq_dma_en |-> irq_o)
        else $error("dma completion not on interrupt line");

    AST_DMA_HOLD: assert property (
        dma_cyc_o && !dma_ack_i |=> dma_cyc_o && $stable(dma_adr_o))
        else $error("dma request dropped before ack");

    AST_DIGOUT: assert property (
        wb_req && wb_we_i && wb_sel_i == 4'hf && reg_adr == ADR_DIGOUT
        |=> dig_o == $past(wb_dat_i[3:0]))
        else $error("digital outputs not updated by write");
endmodule

// ---- sim/aos_host_mem.sv ----
// host memory model answering the sequencer's dma reads
`timescale 1ns/10ps
module aos_host_mem (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // dma read slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] adr_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // answer delay in cycles
    input wire logic [1:0] wait_i
);
    logic [31:0] mem [0:3];
    logic [1:0] cnt_ff;
    // count out the delay, answer once, then scramble the data lines
    always_ff @(posedge clk_i) begin
        if (rst_i || !(cyc_i && stb_i) || ack_o) begin
            cnt_ff <= 2'h0;
            ack_o <= 1'b0;
            dat_o <= rst_i ? 32'h0 : ~dat_o; // stale data must never look valid
        end else if (cnt_ff == wait_i) begin
            ack_o <= 1'b1;
            dat_o <= mem[adr_i[3:2]];
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the analog output sequencer
`timescale 1ns/10ps
module testbench;
    import aos_pkg::*;
    // ----------------------------------------------------------------
    // clock, reset and design
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic trig = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [1:0] slow = 2'h0;
    logic [31:0] rdat, rd_val, dma_adr, dma_dat;
    logic [127:0] dac, model_dac;
    logic [7:0] upd;
    logic [3:0] dig;
    logic ack, dcyc, dstb, dack, irq;
    int mismatches = 0;
    int cmp_count = 0;
    int upd_cnt = 0;
    initial forever #4 clk_i = ~clk_i;
    // count converter loads mid-cycle, so a task resuming on the next rising
    // edge already sees the load that it has just waited for
    always @(negedge clk_i) if (upd !== 8'h00) upd_cnt <= upd_cnt + 1;
    aos_sequencer u_aos_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .dma_cyc_o(dcyc), .dma_stb_o(dstb),
        .dma_adr_o(dma_adr), .dma_dat_i(dma_dat), .dma_ack_i(dack), .ext_trig_i(trig),
        .dac_data_o(dac), .dac_upd_o(upd), .dig_o(dig), .irq_o(irq));
    aos_host_mem u_aos_host_mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(dcyc), .stb_i(dstb),
        .adr_i(dma_adr), .dat_o(dma_dat), .ack_o(dack), .wait_i(slow));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd_val = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(what, 128'(exp), 128'(rd_val));
    endtask
    task automatic push(input int ch, input logic g, input logic b, input logic [15:0] v);
        wb(1'b1, ADR_FIFO, {11'h0, b, g, 3'(ch), v}, 4'hf);
    endtask
    // wait for the next converter load, then judge mask and codes
    task automatic wait_upd(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (upd === 8'h00 && n < 300);
        chk("dac_upd_o", 128'(m), 128'(upd));
        chk("dac_data_o", model_dac, dac);
        if (upd === 8'h00) give_verdict();
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(ADR_CTRL, 32'h0, "ctrl");
        rd(ADR_RATE_A, 32'(RATE_RST), "rate_a");
        rd(ADR_STATUS, 32'h0, "status");
        rd(8'h3c, 32'h0, "unmapped");
        wb(1'b1, ADR_DIGOUT, 32'h5, 4'hf);
        wb(1'b1, ADR_DIGOUT, 32'ha, 4'h3);
        @(posedge clk_i);
        chk("dig_o", 128'h5, 128'(dig));
        $display("reset and register test done");
    endtask
    task automatic t_simcont;
        for (int c = 0; c < 8; c++) begin
            push(c, c == 7, 1'b0, 16'h1000 + 16'(c * 273));
            model_dac[c*16 +: 16] = 16'h1000 + 16'(c * 273);
        end
        wb(1'b1, ADR_CTRL, 32'h14, 4'hf);
        repeat (40) @(posedge clk_i);
        chk("loads before clock", 128'h0, 128'(upd_cnt));
        wb(1'b1, ADR_CTRL, 32'h94, 4'hf);
        wait_upd(8'hff);
        wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
        $display("simultaneous continuous test done");
    endtask
    task automatic t_burst;
        int base;
        wb(1'b1, ADR_RATE_A, 32'h4, 4'hf);
        push(1, 1'b1, 1'b0, 16'h0a0a);
        push(2, 1'b1, 1'b1, 16'h0b0b);
        wb(1'b1, ADR_CTRL, 32'h11, 4'hf);
        base = upd_cnt;
        repeat (40) @(posedge clk_i);
        chk("loads before sync", 128'(base), 128'(upd_cnt));
        wb(1'b1, ADR_CTRL, 32'h91, 4'hf);
        model_dac[16 +: 16] = 16'h0a0a;
        wait_upd(8'hff);
        model_dac[32 +: 16] = 16'h0b0b;
        wait_upd(8'hff);
        base = upd_cnt;
        repeat (40) @(posedge clk_i);
        chk("loads after end", 128'(base), 128'(upd_cnt));
        rd(ADR_STATUS, 32'h0, "status idle");
        wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
        $display("simultaneous burst test done");
    endtask
    task automatic t_seq;
        int base;
        push(3, 1'b1, 1'b0, 16'hbeef);
        push(5, 1'b1, 1'b0, 16'hcafe);
        wb(1'b1, ADR_CTRL, 32'h1a, 4'hf);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            trig <= 1'b1;
            @(posedge clk_i);
            trig <= 1'b0;
            model_dac[(k == 0 ? 3 : 5)*16 +: 16] = k == 0 ? 16'hbeef : 16'hcafe;
            wait_upd(k == 0 ? 8'h08 : 8'h20);
        end
        // sequential burst: idle until sync, then one value per tick up to burst end
        wb(1'b1, ADR_CTRL, 32'h0, 4'hf);
        push(4, 1'b0, 1'b1, 16'h4444);
        push(6, 1'b0, 1'b0, 16'h6666);
        wb(1'b1, ADR_CTRL, 32'h13, 4'hf);
        base = upd_cnt;
        repeat (20) @(posedge clk_i);
        chk("seq loads before sync", 128'(base), 128'(upd_cnt));
        @(posedge clk_i);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
        model_dac[64 +: 16] = 16'h4444;
        wait_upd(8'h10);
        base = upd_cnt;
        repeat (20) @(posedge clk_i);
        chk("seq loads after end", 128'(base), 128'(upd_cnt));
        rd(ADR_STATUS, 32'h00010001, "seq status idle");
        // clear drops the value left behind the burst end
        wb(1'b1, ADR_CTRL, 32'h40, 4'hf);
        $display("channel sequential test done");
    endtask
    task automatic t_dma;
        int n;
        slow <= 2'h2;
        // threshold of two: the flag, and so the interrupt, waits for the last word
        wb(1'b1, ADR_THRESH, 32'h2, 4'hf);
        wb(1'b1, ADR_DMA_ADR, 32'h0, 4'hf);
        wb(1'b1, ADR_CTRL, 32'h100, 4'hf);
        wb(1'b1, ADR_DMA_CNT, 32'h3, 4'hf);
        for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_i);
        chk("irq_o", 128'h1, 128'(irq));
        rd(ADR_STATUS, 32'h00090003, "status after dma");
        rd(ADR_DMA_ADR, 32'hc, "dma address");
        wb(1'b1, ADR_CTRL, 32'h16, 4'hf);
        wb(1'b1, ADR_CTRL, 32'h96, 4'hf);
        model_dac[96 +: 16] = 16'h1234;
        wait_upd(8'h40);
        chk("irq_o masked", 128'h0, 128'(irq));
        $display("dma and threshold test done");
    endtask
    initial begin
        model_dac = 128'h0;
        u_aos_host_mem.mem[0] = 32'hffe61234;
        u_aos_host_mem.mem[1] = 32'h0;
        u_aos_host_mem.mem[2] = 32'h0;
        u_aos_host_mem.mem[3] = 32'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_simcont();
        t_burst();
        t_seq();
        t_dma();
        give_verdict();
    end
endmodule
